// file: rtl/eeprom_bus_slave_write_path.sv
`timescale 1ns/1ps
`default_nettype none

module eeprom_bus_slave_write_path #(
  parameter int ADDR_W = eeprom_pkg::MEM_ADDR_W,
  parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES_DFLT
) (
  // system
  input wire logic mclk,
  input wire logic rst,
  // two-wire bus, scl also clocks the bit capture
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // protection pin
  input wire logic write_inhibit_pin,
  // status
  output logic busy,
  output eeprom_pkg::address_config_s address_config_register,
  output logic id_page_locked,
  // inspection read, array bytes corrected through the group code, identification page bytes read uncorrected
  input wire logic peek_id,
  input wire logic [ADDR_W-1:0] peek_addr,
  output logic [eeprom_pkg::BITS_PER_BYTE-1:0] peek_data
);
  import eeprom_pkg::*;

  localparam int GROUPS = 2 ** (ADDR_W - 2);
  localparam int TW = $clog2(WRITE_CYCLES + 1);
  localparam int WORD_W = GROUP_W + ECC_W;

  typedef struct packed {
    logic smp;
    logic tog;
  } link_s;

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] wc_s;
    logic [2:0] tog_s;
    logic scl_q;
    logic sda_q;
    logic wc_q;
    logic tog_q;
    bus_state_e st;
    logic [3:0] bit_cnt;
    logic [BITS_PER_BYTE-1:0] shreg;
    logic ack_want;
    logic oe;
    logic drive_lvl;
    logic last_data;
    logic arm;
    logic is_id;
    logic [1:0] tgt;
    logic [BITS_PER_BYTE-1:0] addr_hi;
    logic [ADDR_W-1:0] addr;
    logic [PAGE_BYTES-1:0] mask;
    logic [PAGE_BYTES*BITS_PER_BYTE-1:0] pbuf;
    logic pend;
    logic cfg_abort;
    logic lock_req;
    address_config_s cfg_new;
    address_config_s cfg;
    logic id_locked;
    logic [PAGE_OFF_W-1:0] grp;
    logic [TW-1:0] timer;
    logic busy;
    logic [BITS_PER_BYTE-1:0] peek;
  } state_s;

  state_s r;
  state_s n;
  link_s lk_reg;
  link_s lk_next;

  logic [WORD_W-1:0] mem [GROUPS];
  logic [BITS_PER_BYTE-1:0] idpage [PAGE_BYTES];

  function automatic logic [ECC_W-1:0] ecc_code(input logic [GROUP_W-1:0] d);
    logic [ECC_W-1:0] c;
    int j;
    c = '0;
    j = 0;
    for (int p = ECC_FIRST_POS; p <= ECC_LAST_POS; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (d[j])
          c = c ^ p[ECC_W-1:0];
        j = j + 1;
      end
    end
    return c;
  endfunction

  function automatic logic [GROUP_W-1:0] ecc_fix(input logic [WORD_W-1:0] w);
    logic [GROUP_W-1:0] d;
    logic [ECC_W-1:0] s;
    int j;
    d = w[GROUP_W-1:0];
    s = w[WORD_W-1:GROUP_W] ^ ecc_code(w[GROUP_W-1:0]);
    j = 0;
    for (int p = ECC_FIRST_POS; p <= ECC_LAST_POS; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (s == p[ECC_W-1:0])
          d[j] = ~d[j];
        j = j + 1;
      end
    end
    return d;
  endfunction

  // link side: one bit per scl rise, announced by a toggle
  always_comb
  begin
    lk_next.smp = sda_i;
    lk_next.tog = ~lk_reg.tog;
  end

  always_ff @(posedge scl or posedge rst)
  begin
    if (rst)
      lk_reg <= '0;
    else
      lk_reg <= lk_next;
  end

  // stable levels: a change counts once second and third stage agree
  logic scl_lv;
  logic sda_lv;
  logic wc_lv;
  logic tog_lv;
  logic start_det;
  logic stop_det;
  logic scl_fall;
  logic bit_ev;
  logic byte_done;
  logic [BITS_PER_BYTE-1:0] rx_byte;
  logic sel_ok;
  logic write_go;
  logic data_allow;

  assign scl_lv = (r.scl_s[1] == r.scl_s[2]) ? r.scl_s[2] : r.scl_q;
  assign sda_lv = (r.sda_s[1] == r.sda_s[2]) ? r.sda_s[2] : r.sda_q;
  assign wc_lv = (r.wc_s[1] == r.wc_s[2]) ? r.wc_s[2] : r.wc_q;
  assign tog_lv = (r.tog_s[1] == r.tog_s[2]) ? r.tog_s[2] : r.tog_q;
  assign start_det = scl_lv && r.scl_q && r.sda_q && !sda_lv;
  assign stop_det = scl_lv && r.scl_q && !r.sda_q && sda_lv;
  assign scl_fall = r.scl_q && !scl_lv;
  assign bit_ev = tog_lv != r.tog_q;
  assign byte_done = bit_ev && (r.bit_cnt == LAST_DATA_SLOT);
  // sample is settled long before its toggle has crossed
  assign rx_byte = {r.shreg[BITS_PER_BYTE-2:0], lk_reg.smp};
  assign sel_ok = (rx_byte[BITS_PER_BYTE-1:SEL_TYPE_LSB] == TYPE_ARRAY ||
                   rx_byte[BITS_PER_BYTE-1:SEL_TYPE_LSB] == TYPE_AUX) &&
                  rx_byte[SEL_TYPE_LSB-1:SEL_CS_LSB] == r.cfg.chip_select_bits;
  assign write_go = r.st == ST_DATA && r.arm && r.pend;
  always_comb
  begin
    data_allow = 1'b0;
    if (!r.wc_q)
    begin
      unique case (r.tgt)
        TGT_ARRAY: data_allow = 1'b1;
        TGT_IDP: data_allow = !r.id_locked;
        TGT_LOCK: data_allow = !r.id_locked;
        TGT_CFG: data_allow = !r.cfg.address_lock_bit && !r.cfg_abort;
      endcase
    end
  end

  // group re-programming: read, correct, merge, re-encode
  logic [ADDR_W-3:0] grp_idx;
  logic [GROUP_BYTES-1:0] grp_mask;
  logic [GROUP_W-1:0] grp_old;
  logic [GROUP_W-1:0] grp_new;
  logic mem_we;
  logic idp_we;
  logic [GROUP_W-1:0] peek_grp;

  assign peek_grp = ecc_fix(mem[peek_addr[ADDR_W-1:2]]);
  assign grp_idx = {r.addr[ADDR_W-1:PAGE_OFF_W], r.grp[GROUP_SEL_W-1:0]};
  assign grp_mask = r.mask[r.grp[GROUP_SEL_W-1:0]*GROUP_BYTES +: GROUP_BYTES];
  assign grp_old = ecc_fix(mem[grp_idx]);
  always_comb
  begin
    grp_new = grp_old;
    for (int b = 0; b < GROUP_BYTES; b++)
    begin
      if (grp_mask[b])
        grp_new[b*BITS_PER_BYTE +: BITS_PER_BYTE] =
          r.pbuf[(r.grp[GROUP_SEL_W-1:0]*GROUP_BYTES + b)*BITS_PER_BYTE +: BITS_PER_BYTE];
    end
  end
  assign mem_we = r.st == ST_BUSY && r.tgt == TGT_ARRAY && |grp_mask &&
                  r.grp < PAGE_OFF_W'(GROUPS_PER_PAGE);
  assign idp_we = r.st == ST_BUSY && r.tgt == TGT_IDP && r.timer == '0;

  always_comb
  begin
    n = r;
    n.scl_s = {r.scl_s[1:0], scl};
    n.sda_s = {r.sda_s[1:0], sda_i};
    n.wc_s = {r.wc_s[1:0], write_inhibit_pin};
    n.tog_s = {r.tog_s[1:0], lk_reg.tog};
    n.scl_q = scl_lv;
    n.sda_q = sda_lv;
    n.wc_q = wc_lv;
    n.tog_q = tog_lv;
    n.drive_lvl = 1'b0;
    if (peek_id)
      n.peek = idpage[peek_addr[PAGE_OFF_W-1:0]];
    else
      n.peek = peek_grp[peek_addr[1:0]*BITS_PER_BYTE +: BITS_PER_BYTE];
    if (r.st == ST_BUSY)
    begin
      // bus is disconnected for the whole cycle, polling gets no answer
      n.oe = 1'b0;
      n.timer = r.timer + 1'b1;
      if (r.grp < PAGE_OFF_W'(GROUPS_PER_PAGE))
        n.grp = r.grp + 1'b1;
      if (r.timer == '0)
      begin
        if (r.tgt == TGT_LOCK && r.lock_req)
          n.id_locked = 1'b1;
        if (r.tgt == TGT_CFG)
          n.cfg = r.cfg_new;
      end
      if (r.timer == TW'(WRITE_CYCLES - 1))
      begin
        n.st = ST_IDLE;
        n.mask = '0;
        n.pend = 1'b0;
      end
    end
    else if (start_det)
    begin
      n.st = ST_SEL;
      n.bit_cnt = '0;
      n.oe = 1'b0;
      n.ack_want = 1'b0;
      n.arm = 1'b0;
    end
    else if (stop_det)
    begin
      n.oe = 1'b0;
      n.ack_want = 1'b0;
      n.arm = 1'b0;
      if (write_go)
      begin
        n.st = ST_BUSY;
        n.grp = '0;
        n.timer = '0;
      end
      else
        n.st = ST_IDLE;
    end
    else if (r.st != ST_IDLE)
    begin
      // read state still counts bits so its select gets the acknowledge, data out is not modelled
      if (scl_fall)
      begin
        if (r.bit_cnt == ACK_SLOT && r.ack_want)
          n.oe = 1'b1;
        else if (r.bit_cnt == '0)
          n.oe = 1'b0;
        // a stop needs the tenth-slot rise, so only that slot's fall disarms
        if (r.bit_cnt != '0)
          n.arm = 1'b0;
      end
      if (bit_ev)
      begin
        if (r.bit_cnt == ACK_SLOT)
        begin
          n.bit_cnt = '0;
          n.arm = r.last_data && r.ack_want;
          n.ack_want = 1'b0;
        end
        else
        begin
          n.shreg = rx_byte;
          n.bit_cnt = r.bit_cnt + 1'b1;
        end
        if (byte_done)
        begin
          n.ack_want = 1'b1;
          n.last_data = 1'b0;
          unique case (r.st)
            ST_SEL:
            begin
              if (!sel_ok)
              begin
                n.st = ST_IDLE;
                n.ack_want = 1'b0;
              end
              else if (rx_byte[0])
                n.st = ST_READ;
              else
              begin
                n.st = ST_ADDR_HI;
                n.is_id = rx_byte[SEL_TYPE_LSB] == TYPE_AUX[0];
              end
            end
            ST_ADDR_HI:
            begin
              n.addr_hi = rx_byte;
              n.st = ST_ADDR_LO;
            end
            ST_ADDR_LO:
            begin
              n.addr = {r.addr_hi[ADDR_W-BITS_PER_BYTE-1:0], rx_byte};
              n.st = ST_DATA;
              n.mask = '0;
              n.pend = 1'b0;
              n.cfg_abort = 1'b0;
              n.lock_req = 1'b0;
              if (!r.is_id)
                n.tgt = TGT_ARRAY;
              else if (r.addr_hi[BITS_PER_BYTE-1:CFG_SEL_LSB] == CFG_SEL_CODE)
                n.tgt = TGT_CFG;
              else if (r.addr_hi[LOCK_SEL_BIT])
                n.tgt = TGT_LOCK;
              else
                n.tgt = TGT_IDP;
            end
            ST_DATA:
            begin
              n.last_data = 1'b1;
              n.ack_want = data_allow;
              if (data_allow)
              begin
                n.pend = 1'b1;
                unique case (r.tgt)
                  TGT_ARRAY, TGT_IDP:
                  begin
                    n.pbuf[r.addr[PAGE_OFF_W-1:0]*BITS_PER_BYTE +: BITS_PER_BYTE] = rx_byte;
                    n.mask[r.addr[PAGE_OFF_W-1:0]] = 1'b1;
                    n.addr[PAGE_OFF_W-1:0] = r.addr[PAGE_OFF_W-1:0] + 1'b1;
                  end
                  TGT_LOCK: n.lock_req = r.lock_req | rx_byte[LOCK_DATA_BIT];
                  TGT_CFG:
                  begin
                    // a second byte cancels the whole register write
                    if (r.pend)
                    begin
                      n.pend = 1'b0;
                      n.cfg_abort = 1'b1;
                      n.ack_want = 1'b0;
                    end
                    else
                      n.cfg_new = rx_byte[SEL_TYPE_LSB-1:0];
                  end
                endcase
              end
            end
            default: n.ack_want = 1'b0;
          endcase
        end
      end
    end
    n.busy = n.st == ST_BUSY;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      r <= '0;
      r.st <= ST_IDLE;
      r.cfg <= CFG_FACTORY;
    end
    else
      r <= n;
  end

  // non-volatile storage: no reset
  always_ff @(posedge mclk)
  begin
    if (mem_we)
      mem[grp_idx] <= {ecc_code(grp_new), grp_new};
    if (idp_we)
    begin
      for (int i = 0; i < PAGE_BYTES; i++)
      begin
        if (r.mask[i])
          idpage[i] <= r.pbuf[i*BITS_PER_BYTE +: BITS_PER_BYTE];
      end
    end
  end

  assign sda_o = r.drive_lvl;
  assign sda_oe = r.oe;
  assign busy = r.busy;
  assign address_config_register = r.cfg;
  assign id_page_locked = r.id_locked;
  assign peek_data = r.peek;

  logic [PAGE_OFF_W-1:0] off_now;
  logic [ADDR_W-PAGE_OFF_W-1:0] page_now;
  assign off_now = r.addr[PAGE_OFF_W-1:0];
  assign page_now = r.addr[ADDR_W-1:PAGE_OFF_W];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_busy_quiet;
    (r.st == ST_BUSY) |-> !r.oe ##1 (r.st == ST_BUSY || r.st == ST_IDLE);
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("bus touched during write cycle");

  property p_start;
    (start_det && r.st != ST_BUSY) |=> (r.st == ST_SEL && r.bit_cnt == '0 && !r.oe);
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_stop;
    (stop_det && r.st != ST_BUSY && !write_go) |=> (r.st == ST_IDLE && !r.oe);
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not end communication");

  property p_cycle_cause;
    $rose(r.st == ST_BUSY) |-> $past(stop_det) && $past(r.arm) && $past(r.pend);
  endproperty
  a_cycle_cause: assert property (p_cycle_cause) else $error("write cycle without tenth-slot stop");

  property p_mismatch;
    (byte_done && r.st == ST_SEL && !sel_ok && !start_det && !stop_det) |=> (r.st == ST_IDLE && !r.ack_want);
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("foreign select acknowledged");

  property p_sel_write;
    (byte_done && r.st == ST_SEL && sel_ok && !rx_byte[0] && !start_det && !stop_det)
      |=> (r.st == ST_ADDR_HI && r.ack_want);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("matching write select not accepted");

  property p_inhibit;
    (byte_done && r.st == ST_DATA && r.wc_q && !start_det && !stop_det) |=> (!r.ack_want && $stable(r.mask));
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("data accepted while inhibited");

  property p_ack_drive;
    (scl_fall && r.bit_cnt == ACK_SLOT && r.ack_want && r.st != ST_BUSY && !start_det && !stop_det) |=> r.oe;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("acknowledge not driven");

  property p_page_wrap;
    (byte_done && r.st == ST_DATA && r.tgt == TGT_ARRAY && data_allow && !start_det && !stop_det)
      |=> (off_now == PAGE_OFF_W'($past(off_now) + 1'b1) && $stable(page_now));
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("in-page counter wrong");

  property p_cfg_frozen;
    r.cfg.address_lock_bit |=> $stable(r.cfg);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen) else $error("locked config changed");

  property p_cycle_len;
    $rose(r.st == ST_BUSY) |-> (r.st == ST_BUSY)[*8];
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("write cycle too short");

endmodule // eeprom_bus_slave_write_path

`default_nettype wire

// file: shared/eeprom_pkg.sv
package eeprom_pkg;

  // system clock and write cycle time
  localparam int CLK_MHZ = 200;
  localparam int T_WRITE_US = 5000;
  localparam int WRITE_CYCLES_DFLT = T_WRITE_US * CLK_MHZ;

  // array organisation
  localparam int MEM_ADDR_W = 15;
  localparam int BITS_PER_BYTE = 8;
  localparam int PAGE_BYTES = 64;
  localparam int PAGE_OFF_W = 6;
  localparam int GROUP_BYTES = 4;
  localparam int GROUP_W = GROUP_BYTES * BITS_PER_BYTE;
  localparam int GROUPS_PER_PAGE = PAGE_BYTES / GROUP_BYTES;
  localparam int GROUP_SEL_W = PAGE_OFF_W - 2;

  // single-error-correcting code over one group
  localparam int ECC_W = 6;
  localparam int ECC_FIRST_POS = 3;
  localparam int ECC_LAST_POS = 38;

  // select byte and address decode
  localparam logic [3:0] TYPE_ARRAY = 4'ha;
  localparam logic [3:0] TYPE_AUX = 4'hb;
  localparam int SEL_TYPE_LSB = 4;
  localparam int SEL_CS_LSB = 1;
  localparam logic [2:0] CFG_SEL_CODE = 3'h6;
  localparam int CFG_SEL_LSB = 5;
  localparam int LOCK_SEL_BIT = 2;
  localparam int LOCK_DATA_BIT = 1;

  // bit slot of the acknowledge within a byte frame
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_DATA_SLOT = 4'h7;

  // write targets
  localparam logic [1:0] TGT_ARRAY = 2'h0;
  localparam logic [1:0] TGT_IDP = 2'h1;
  localparam logic [1:0] TGT_LOCK = 2'h2;
  localparam logic [1:0] TGT_CFG = 2'h3;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_SEL = 7'h02,
    ST_ADDR_HI = 7'h04,
    ST_ADDR_LO = 7'h08,
    ST_DATA = 7'h10,
    ST_READ = 7'h20,
    ST_BUSY = 7'h40
  } bus_state_e;

  typedef struct packed {
    logic [2:0] chip_select_bits;
    logic address_lock_bit;
  } address_config_s;

  localparam address_config_s CFG_FACTORY = 4'h0;

endpackage

// file: verif/i2c_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
  // lines driven by the master
  output logic scl,
  output logic sda_rel,
  // resolved data wire
  input wire logic sda_wire
);
  // clock stands high outside frames, data released to the pull-up
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // odd offset keeps the link timing out of phase with mclk
  task automatic start_cond();
    #13.7;
    sda_rel = 1'b1;
    #30 scl = 1'b1;
    #30 sda_rel = 1'b0;
    #30 scl = 1'b0;
  endtask

  task automatic bit_cycle(input logic v, output logic s);
    #30 sda_rel = v;
    #30 scl = 1'b1;
    #30 s = sda_wire;
    #30 scl = 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cycle(b[i], s);
    bit_cycle(1'b1, s);
    ack = ~s;
  endtask

  task automatic stop_cond();
    #30 sda_rel = 1'b0;
    #30 scl = 1'b1;
    #30 sda_rel = 1'b1;
    #30;
  endtask
endmodule // i2c_master_model

`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import eeprom_pkg::*;
  localparam int WCYC = 300;
  logic mclk, rst, scl, sda_rel, sda_i, sda_o, sda_oe, write_inhibit_pin, busy, id_page_locked, peek_id, a;
  address_config_s address_config_register;
  logic [MEM_ADDR_W-1:0] peek_addr, ad;
  logic [7:0] peek_data, v, hi, lo;
  logic [7:0] dq[$];
  logic [7:0] ref_mem[int];
  logic [2:0] cs;
  int bad_count, check_count, cycles;

  // open-drain wire with pull-up
  assign sda_i = sda_rel & (sda_oe ? sda_o : 1'b1);

  eeprom_bus_slave_write_path #(.ADDR_W(MEM_ADDR_W), .WRITE_CYCLES(WCYC)) u_dut (
    .mclk(mclk), .rst(rst), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .write_inhibit_pin(write_inhibit_pin), .busy(busy), .address_config_register(address_config_register),
    .id_page_locked(id_page_locked), .peek_id(peek_id), .peek_addr(peek_addr), .peek_data(peek_data)
  );

  i2c_master_model u_master (.scl(scl), .sda_rel(sda_rel), .sda_wire(sda_i));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  function automatic logic [7:0] sel(input logic [3:0] t, input logic rd);
    return {t, cs, rd};
  endfunction

  // in-page roll-over
  function automatic logic [14:0] pg(input logic [14:0] b, input int i);
    return {b[14:6], 6'(int'(b[5:0]) + i)};
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] s, input logic [7:0] h, input logic [7:0] l, input logic dack);
    logic k;
    u_master.start_cond();
    u_master.send_byte(s, k);
    check(k, 1'b1);
    u_master.send_byte(h, k);
    check(k, 1'b1);
    u_master.send_byte(l, k);
    check(k, 1'b1);
    foreach (dq[i])
    begin
      u_master.send_byte(dq[i], k);
      check(k, dack);
    end
    u_master.stop_cond();
  endtask

  task automatic poll(input logic [7:0] s, output logic k);
    u_master.start_cond();
    u_master.send_byte(s, k);
    u_master.stop_cond();
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < WCYC + 100)
    begin
      @(posedge mclk);
      n++;
    end
    check(n < WCYC + 100, 1'b1);
  endtask

  task automatic after_write(input logic cyc);
    logic k;
    @(posedge mclk);
    #1;
    check(busy, cyc);
    if (cyc)
    begin
      poll(sel(TYPE_ARRAY, 1'b0), k);
      check(k, 1'b0);
      wait_idle();
    end
    poll(sel(TYPE_ARRAY, 1'b0), k);
    check(k, 1'b1);
  endtask

  task automatic peek(input logic id, input logic [14:0] p, output logic [7:0] r);
    @(posedge mclk);
    #1;
    peek_id = id;
    peek_addr = p;
    @(posedge mclk);
    #1;
    r = peek_data;
  endtask

  // page write of dq at b, mirrored into the reference
  task automatic page_wr(input logic [14:0] b);
    wr(sel(TYPE_ARRAY, 1'b0), {1'($urandom), b[14:8]}, b[7:0], 1'b1);
    foreach (dq[i])
      ref_mem[int'(pg(b, i))] = dq[i];
    after_write(1'b1);
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      bad_count++;
      stop_test();
    end
  end

  initial
  begin
    rst = 1'b1;
    write_inhibit_pin = 1'b0;
    peek_id = 1'b0;
    peek_addr = '0;
    cs = 3'h0;
    void'($urandom(32'h5697));
    repeat (8) @(posedge mclk);
    #1 rst = 1'b0;
    repeat (12) @(posedge mclk);
    check(address_config_register, CFG_FACTORY);
    check(busy, 1'b0);
    // random byte writes
    for (int k = 0; k < 3; k++)
    begin
      ad = 15'($urandom);
      dq = '{8'($urandom)};
      page_wr(ad);
    end
    // full page, then a short write that rolls over the page end
    ad = {9'($urandom), 6'h00};
    dq = {};
    for (int i = 0; i < PAGE_BYTES; i++)
      dq.push_back(8'($urandom));
    page_wr(ad);
    dq = '{8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom)};
    page_wr(pg(ad, 62));
    foreach (ref_mem[i])
    begin
      peek(1'b0, 15'(i), v);
      check(v, ref_mem[i]);
    end
    // stop after the address bytes starts nothing
    dq = {};
    wr(sel(TYPE_ARRAY, 1'b0), 8'h00, 8'h00, 1'b1);
    after_write(1'b0);
    // wrong chip select, wrong type, then read direction
    poll({TYPE_ARRAY, cs ^ 3'h1, 1'b0}, a);
    check(a, 1'b0);
    poll({4'hc, cs, 1'b0}, a);
    check(a, 1'b0);
    poll(sel(TYPE_ARRAY, 1'b1), a);
    check(a, 1'b1);
    // inhibited writes change nothing
    @(posedge mclk);
    #1 write_inhibit_pin = 1'b1;
    dq = '{8'($urandom), 8'($urandom)};
    wr(sel(TYPE_ARRAY, 1'b0), ad[14:8], ad[7:0], 1'b0);
    dq = '{8'h0a};
    wr(sel(TYPE_AUX, 1'b0), 8'hc0, 8'h00, 1'b0);
    repeat (8) @(posedge mclk);
    wait_idle();
    peek(1'b0, ad, v);
    check(v, ref_mem[int'(ad)]);
    check(address_config_register, CFG_FACTORY);
    @(posedge mclk);
    #1 write_inhibit_pin = 1'b0;
    // identification page, then its lock
    lo = {2'($urandom), 6'h20};
    dq = '{8'($urandom), 8'($urandom)};
    wr(sel(TYPE_AUX, 1'b0), 8'h1b, lo, 1'b1);
    after_write(1'b1);
    peek(1'b1, 15'(lo[5:0] + 6'h1), v);
    check(v, dq[1]);
    check(id_page_locked, 1'b0);
    hi = dq[0];
    dq = '{8'hfe};
    wr(sel(TYPE_AUX, 1'b0), 8'h04, 8'h00, 1'b1);
    after_write(1'b1);
    check(id_page_locked, 1'b1);
    dq = '{8'h55};
    wr(sel(TYPE_AUX, 1'b0), 8'h00, lo, 1'b0);
    repeat (8) @(posedge mclk);
    wait_idle();
    peek(1'b1, 15'(lo[5:0]), v);
    check(v, hi);
    // new chip select, then freeze the register
    dq = '{8'h0a};
    wr(sel(TYPE_AUX, 1'b0), {3'h6, 5'($urandom)}, 8'($urandom), 1'b1);
    cs = 3'h5;
    after_write(1'b1);
    check(address_config_register, 4'ha);
    poll({TYPE_ARRAY, 3'h0, 1'b0}, a);
    check(a, 1'b0);
    dq = '{8'h0b};
    wr(sel(TYPE_AUX, 1'b0), 8'hc0, 8'h00, 1'b1);
    after_write(1'b1);
    dq = '{8'h02};
    wr(sel(TYPE_AUX, 1'b0), 8'hc0, 8'h00, 1'b0);
    repeat (8) @(posedge mclk);
    wait_idle();
    check(address_config_register, 4'hb);
    stop_test();
  end
endmodule // testbench

`default_nettype wire
